// file: include/cerb_pkg.sv
package cerb_pkg;

    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SDP,   // simple dual-port: a writes, b reads
        MODE_TDP,   // true dual-port: both ports read and write
        MODE_SP,    // single-port on port a only
        MODE_SP2,   // two single-port memories, one per half
        MODE_FIFO   // a pushes, b pops
    } cerb_mode_e;

    // ------------------------------------------------------------
    // size variants and geometry
    // ------------------------------------------------------------
    localparam int VAR_SMALL  = 0;  // small_ram_block, 32 rows of 18
    localparam int VAR_MEDIUM = 1;  // medium_ram_block, 128 rows of 36
    localparam int VAR_LARGE  = 2;  // large block, 4k rows of 144
    localparam int ROW_LOG  [3] = '{5, 7, 12};  // log2 of rows
    localparam int BYTE_LOG [3] = '{1, 2, 4};   // log2 of bytes per row
    localparam int MIN_LW   [3] = '{0, 0, 3};   // narrowest port, log2
    localparam int LANE_BITS = 9;               // byte plus parity bit
    localparam int BYTE_BITS = 8;               // data bits per byte
    localparam int PAR_LW    = 3;               // log2 width of one byte

    // ------------------------------------------------------------
    // port widths and reset values
    // ------------------------------------------------------------
    localparam int DW  = 144;  // widest physical row
    localparam int AW  = 19;   // widest unit address
    localparam int LWW = 3;    // width code field
    localparam logic [DW-1:0] RDW_FILL = {DW{1'b1}};  // undefined read pattern
    localparam logic [DW-1:0] Q_RST    = '0;          // output after clear

endpackage

// file: include/cerb_port_if.sv
// registered request of one port, from input stage to array
interface cerb_port_if;
    logic                        en;    // access strobe, one cycle
    logic                        we;    // write strobe, one cycle
    logic [cerb_pkg::AW-1:0]     addr;  // held unit address
    logic [cerb_pkg::DW-1:0]     data;  // held write data

    modport src (output en, output we, output addr, output data);
    modport dst (input en, input we, input addr, input data);
endinterface

// file: design/cerb_port_regs.sv
module cerb_port_regs #(
    parameter bit CLR_EN = 1'b1  // input clear reaches these registers
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    clr_i,
    input  wire logic                    ce_i,
    input  wire logic                    en_i,
    input  wire logic                    we_i,
    input  wire logic [cerb_pkg::AW-1:0] addr_i,
    input  wire logic [cerb_pkg::DW-1:0] data_i,
    cerb_port_if.src                     regs
);

    // ------------------------------------------------------------
    // clear gating
    // ------------------------------------------------------------
    logic clr_act;  // asynchronous clear after variant gating

    // constant gate, so no glitch path into the clear pin
    assign clr_act = CLR_EN & clr_i;

    // ------------------------------------------------------------
    // input registers
    // ------------------------------------------------------------
    logic                    en_ff;    // registered access
    logic                    we_ff;    // registered write
    logic [cerb_pkg::AW-1:0] addr_ff;  // registered address
    logic [cerb_pkg::DW-1:0] data_ff;  // registered data

    // strobes live one cycle so each port edge writes once
    always_ff @(posedge clk_i or posedge clr_act) begin
        if (clr_act) begin
            en_ff <= 1'b0;
            we_ff <= 1'b0;
        end else if (!rst_n_i) begin
            en_ff <= 1'b0;
            we_ff <= 1'b0;
        end else begin
            en_ff <= ce_i & en_i;
            we_ff <= ce_i & en_i & we_i;
        end
    end

    // address and data held between port edges
    always_ff @(posedge clk_i or posedge clr_act) begin
        if (clr_act) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else if (!rst_n_i) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else if (ce_i) begin
            addr_ff <= addr_i;
            data_ff <= data_i;
        end
    end

    assign regs.en   = en_ff;
    assign regs.we   = we_ff;
    assign regs.addr = addr_ff;
    assign regs.data = data_ff;

endmodule

// file: design/cerb_ram_top.sv
// What this block does
// - three sizes, each with its width set
// - simple dual, single-port, fifo, parity
// - medium and large add true dual-port
// - simple dual collision reads old or undefined
// - single-port write shows new data on output
// - large variant clears output registers only
// - collision: small, medium choose; large undefined
// - inputs registered, internal one-cycle write strobe
// - bypassable outputs, flow-through simple dual reads on small and medium
// - ports may differ in width
// - medium holds two half-size single-port memories
// - input clear immediate, output sees next edge
// - output clear visible on outputs immediately
// - one parity bit stored per byte
// - small: writes on port a, reads on b, or on a in single-port mode
module cerb_ram_top #(
    parameter int VARIANT = cerb_pkg::VAR_MEDIUM  // size variant
) (
    input  wire logic                     SYS_CLK_I,
    input  wire logic                     RSTN_I,
    input  cerb_pkg::cerb_mode_e          MODE_I,
    input  wire logic [cerb_pkg::LWW-1:0] A_LW_I,
    input  wire logic                     A_PAR_I,
    input  wire logic [cerb_pkg::LWW-1:0] B_LW_I,
    input  wire logic                     B_PAR_I,
    input  wire logic                     OUTREG_I,
    input  wire logic                     FLOW_I,
    input  wire logic                     RDW_OLD_I,
    input  wire logic                     INCLR_I,
    input  wire logic                     OUTCLR_I,
    input  wire logic                     A_CE_I,
    input  wire logic                     A_EN_I,
    input  wire logic                     A_WE_I,
    input  wire logic [cerb_pkg::AW-1:0]  A_ADDR_I,
    input  wire logic [cerb_pkg::DW-1:0]  A_DATA_I,
    input  wire logic                     B_CE_I,
    input  wire logic                     B_EN_I,
    input  wire logic                     B_WE_I,
    input  wire logic [cerb_pkg::AW-1:0]  B_ADDR_I,
    input  wire logic [cerb_pkg::DW-1:0]  B_DATA_I,
    output logic      [cerb_pkg::DW-1:0]  A_Q_O,
    output logic      [cerb_pkg::DW-1:0]  B_Q_O,
    output logic                          FIFO_FULL_O,
    output logic                          FIFO_EMPTY_O,
    output logic                          CFG_ERR_O
);

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int AW  = cerb_pkg::AW;
    localparam int DW  = cerb_pkg::DW;
    localparam int CW  = AW + 1;                          // fifo count width
    localparam int BL  = cerb_pkg::BYTE_LOG[VARIANT];
    localparam int RL  = cerb_pkg::ROW_LOG[VARIANT];
    localparam int UW  = BL + cerb_pkg::PAR_LW;          // log2 data bits per row
    localparam bit LARGE  = (VARIANT == cerb_pkg::VAR_LARGE);
    localparam bit CLR_IN = !LARGE;                      // input clear reach

    logic [DW-1:0] mem [1 << RL];  // rows of bytes with parity lanes

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // port width in bits; parity widths are nine per byte
    function automatic int wid_f(input logic [2:0] lw, input logic par);
        return par ? (cerb_pkg::LANE_BITS << (int'(lw) - cerb_pkg::PAR_LW)) : (1 << lw);
    endfunction

    // data bit to physical bit; lane bit 8 holds the parity
    function automatic int pos_f(input int i);
        return cerb_pkg::LANE_BITS * (i / cerb_pkg::BYTE_BITS) + (i % cerb_pkg::BYTE_BITS);
    endfunction

    function automatic logic [DW-1:0] rd_f(input logic [DW-1:0] row, input logic [7:0] col,
                                           input logic [2:0] lw, input logic par);
        logic [DW-1:0] r;
        int w;
        int s;
        r = '0;
        w = wid_f(lw, par);
        for (int i = 0; i < DW; i++) begin
            s = par ? int'(col) * w + i : pos_f(int'(col) * w + i);
            if (i < w && s < DW) begin
                r[i] = row[s];
            end
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] wr_f(input logic [DW-1:0] row, input logic [7:0] col,
                                           input logic [2:0] lw, input logic par,
                                           input logic [DW-1:0] d);
        logic [DW-1:0] r;
        int w;
        int s;
        r = row;
        w = wid_f(lw, par);
        for (int i = 0; i < DW; i++) begin
            s = par ? int'(col) * w + i : pos_f(int'(col) * w + i);
            if (i < w && s < DW) begin
                r[s] = d[i];
            end
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] msk_f(input logic [2:0] lw, input logic par);
        logic [DW-1:0] m;
        for (int i = 0; i < DW; i++) begin
            m[i] = (i < wid_f(lw, par));
        end
        return m;
    endfunction

    // width legal for this variant; parity only from one byte up
    function automatic logic cfg_f(input logic [2:0] lw, input logic par);
        return int'(lw) >= cerb_pkg::MIN_LW[VARIANT] && int'(lw) <= UW
               && (!par || int'(lw) >= cerb_pkg::PAR_LW);
    endfunction

    function automatic logic [RL-1:0] row_f(input logic [AW-1:0] a, input logic [2:0] lw);
        logic [AW-1:0] s;
        s = a >> (UW - int'(lw));
        return s[RL-1:0];
    endfunction

    function automatic logic [7:0] col_f(input logic [AW-1:0] a, input logic [2:0] lw);
        logic [AW-1:0] m;
        m = (AW'(1) << (UW - int'(lw))) - AW'(1);
        return 8'(a & m);
    endfunction

    // ------------------------------------------------------------
    // input registers, one stage per port
    // ------------------------------------------------------------
    cerb_port_if a_if ();
    cerb_port_if b_if ();

    // port a carries every write of the small block on its enable
    cerb_port_regs #(.CLR_EN(CLR_IN)) u_port_a (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RSTN_I),
        .clr_i   (INCLR_I),
        .ce_i    (A_CE_I),
        .en_i    (A_EN_I),
        .we_i    (A_WE_I),
        .addr_i  (A_ADDR_I),
        .data_i  (A_DATA_I),
        .regs    (a_if.src)
    );

    cerb_port_regs #(.CLR_EN(CLR_IN)) u_port_b (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RSTN_I),
        .clr_i   (INCLR_I),
        .ce_i    (B_CE_I),
        .en_i    (B_EN_I),
        .we_i    (B_WE_I),
        .addr_i  (B_ADDR_I),
        .data_i  (B_DATA_I),
        .regs    (b_if.src)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [AW-1:0] wptr_ff, rptr_ff;   // fifo pointers, unit addresses
    logic [CW-1:0] cnt_ff;             // fifo fill level
    logic [CW-1:0] cap;                // fifo depth at port a width
    logic          fifo, two, cfg_err, old_ok;
    logic          a_wr, a_rd, b_wr, b_rd, a_upd, b_flow;
    logic [RL-1:0] a_row, b_row, f_row;
    logic [7:0]    a_col, b_col, f_col;
    logic [DW-1:0] a_old, b_old, a_msk, b_msk, a_rdv, b_rdv, f_rd;

    always_comb begin
        fifo = (MODE_I == cerb_pkg::MODE_FIFO);
        two  = (MODE_I != cerb_pkg::MODE_SP);
        // true dual only above small, split mode only on medium
        cfg_err = !cfg_f(A_LW_I, A_PAR_I)
                | (two & (!cfg_f(B_LW_I, B_PAR_I) | (A_PAR_I != B_PAR_I)))
                | ((VARIANT == cerb_pkg::VAR_SMALL) & (MODE_I == cerb_pkg::MODE_TDP))
                | ((VARIANT != cerb_pkg::VAR_MEDIUM) & (MODE_I == cerb_pkg::MODE_SP2))
                | (fifo & (A_LW_I != B_LW_I));
        old_ok = RDW_OLD_I & !LARGE;
        cap = CW'(1) << (RL + UW - int'(A_LW_I));
        FIFO_FULL_O  = (cnt_ff == cap);
        FIFO_EMPTY_O = (cnt_ff == '0);
        CFG_ERR_O    = cfg_err;
        // a writes in every mode; reads only where a is a read port
        a_wr = a_if.en & a_if.we & !cfg_err & !(fifo & FIFO_FULL_O);
        a_rd = a_if.en & !a_if.we & !cfg_err & (MODE_I == cerb_pkg::MODE_TDP
               || MODE_I == cerb_pkg::MODE_SP || MODE_I == cerb_pkg::MODE_SP2);
        b_wr = b_if.en & b_if.we & !cfg_err & (MODE_I == cerb_pkg::MODE_TDP
               || MODE_I == cerb_pkg::MODE_SP2);
        b_rd = b_if.en & !b_if.we & !cfg_err & two & !(fifo & FIFO_EMPTY_O);
        a_upd = a_rd | (a_wr & !fifo & (MODE_I != cerb_pkg::MODE_SDP));
        // each port may run its own width over the same rows
        a_row = row_f(fifo ? wptr_ff : a_if.addr, A_LW_I);
        a_col = col_f(fifo ? wptr_ff : a_if.addr, A_LW_I);
        b_row = row_f(fifo ? rptr_ff : b_if.addr, B_LW_I);
        b_col = col_f(fifo ? rptr_ff : b_if.addr, B_LW_I);
        if (MODE_I == cerb_pkg::MODE_SP2) begin
            a_row[RL-1] = 1'b0;
            b_row[RL-1] = 1'b1;
        end
        a_msk = msk_f(A_LW_I, A_PAR_I);
        b_msk = msk_f(B_LW_I, B_PAR_I);
        a_old = rd_f(mem[a_row], a_col, A_LW_I, A_PAR_I);
        b_old = rd_f(mem[b_row], b_col, B_LW_I, B_PAR_I);
        // own write is shown at once; cross write gives old or fill
        if (a_wr) begin
            a_rdv = a_if.data & a_msk;
        end else if (b_wr && b_row == a_row && !old_ok) begin
            a_rdv = cerb_pkg::RDW_FILL & a_msk;
        end else begin
            a_rdv = a_old;
        end
        if (b_wr) begin
            b_rdv = b_if.data & b_msk;
        end else if (a_wr && a_row == b_row && !old_ok) begin
            b_rdv = cerb_pkg::RDW_FILL & b_msk;
        end else begin
            b_rdv = b_old;
        end
        // flow-through: read address taken ahead of its register
        b_flow = FLOW_I & !OUTREG_I & !LARGE & (MODE_I == cerb_pkg::MODE_SDP);
        f_row  = row_f(B_ADDR_I, B_LW_I);
        f_col  = col_f(B_ADDR_I, B_LW_I);
        if (a_wr && a_row == f_row && !old_ok) begin
            f_rd = cerb_pkg::RDW_FILL & b_msk;
        end else begin
            f_rd = rd_f(mem[f_row], f_col, B_LW_I, B_PAR_I);
        end
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // write happens on the edge after capture: the strobe is internal
    always_ff @(posedge SYS_CLK_I) begin
        if (b_wr) begin
            mem[b_row] <= wr_f(mem[b_row], b_col, B_LW_I, B_PAR_I, b_if.data);
        end
        // shared row: a lays its bits over b's, so both writes land, a wins overlaps
        if (a_wr) begin
            mem[a_row] <= wr_f((b_wr && b_row == a_row) ? wr_f(mem[b_row], b_col, B_LW_I,
                               B_PAR_I, b_if.data) : mem[a_row], a_col, A_LW_I, A_PAR_I,
                               a_if.data);
        end
    end

    // ------------------------------------------------------------
    // fifo pointers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!RSTN_I || !fifo) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end else begin
            if (a_wr) begin
                wptr_ff <= (wptr_ff + AW'(1)) & AW'(cap - CW'(1));
            end
            if (b_rd) begin
                rptr_ff <= (rptr_ff + AW'(1)) & AW'(cap - CW'(1));
            end
            cnt_ff <= cnt_ff + CW'(a_wr) - CW'(b_rd);
        end
    end

    // ------------------------------------------------------------
    // output stages
    // ------------------------------------------------------------
    logic [DW-1:0] a_q0_ff, a_q1_ff, b_q0_ff, b_q1_ff;  // read, pipeline

    // clear acts without the clock; reset gives cleared outputs
    always_ff @(posedge SYS_CLK_I or posedge OUTCLR_I) begin
        if (OUTCLR_I) begin
            a_q0_ff <= cerb_pkg::Q_RST;
            a_q1_ff <= cerb_pkg::Q_RST;
        end else if (!RSTN_I) begin
            a_q0_ff <= cerb_pkg::Q_RST;
            a_q1_ff <= cerb_pkg::Q_RST;
        end else begin
            if (a_upd) begin
                a_q0_ff <= a_rdv;
            end
            if (A_CE_I) begin
                a_q1_ff <= a_q0_ff;
            end
        end
    end

    // b output pipeline runs on b's own enable
    always_ff @(posedge SYS_CLK_I or posedge OUTCLR_I) begin
        if (OUTCLR_I) begin
            b_q0_ff <= cerb_pkg::Q_RST;
            b_q1_ff <= cerb_pkg::Q_RST;
        end else if (!RSTN_I) begin
            b_q0_ff <= cerb_pkg::Q_RST;
            b_q1_ff <= cerb_pkg::Q_RST;
        end else begin
            if (b_flow) begin
                if (B_CE_I && B_EN_I && !B_WE_I && !cfg_err) begin
                    b_q0_ff <= f_rd;
                end
            end else if (b_rd || b_wr) begin
                b_q0_ff <= b_rdv;
            end
            if (B_CE_I) begin
                b_q1_ff <= b_q0_ff;
            end
        end
    end

    assign A_Q_O = OUTREG_I ? a_q1_ff : a_q0_ff;
    assign B_Q_O = OUTREG_I ? b_q1_ff : b_q0_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_OUTCLR: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        OUTCLR_I |-> (A_Q_O == '0 && B_Q_O == '0))
        else $error("output clear not seen on outputs");
    AST_INCLR: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (CLR_IN && INCLR_I) |-> (!a_wr && !b_wr && !a_if.en))
        else $error("input clear did not cancel request");
    AST_LARGE_KEEP: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (!CLR_IN && INCLR_I && A_CE_I && A_EN_I) |=> a_if.en)
        else $error("large block input register was cleared");
    AST_STROBE: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I || INCLR_I)
        (a_if.we && !(A_CE_I && A_EN_I && A_WE_I)) |=> !a_if.we)
        else $error("write strobe longer than one port edge");
    AST_SP_THRU: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (MODE_I == cerb_pkg::MODE_SP && a_wr && !OUTREG_I && !OUTCLR_I)
        |=> A_Q_O == $past(a_if.data & a_msk))
        else $error("single-port write not shown unregistered");
    AST_SP_REG: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (MODE_I == cerb_pkg::MODE_SP && a_wr && OUTREG_I && !OUTCLR_I)
        ##1 (A_CE_I && !OUTCLR_I) |=> A_Q_O == $past(a_if.data & a_msk, 2))
        else $error("single-port write not shown after register");
    AST_RDW_OLD: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (old_ok && b_rd && a_wr && a_row == b_row && !b_flow && !OUTREG_I && !OUTCLR_I)
        |=> B_Q_O == $past(b_old))
        else $error("collision read did not return old data");
    AST_RDW_UNDEF: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (!old_ok && b_rd && a_wr && a_row == b_row && !b_flow && !OUTREG_I && !OUTCLR_I)
        |=> B_Q_O == $past(cerb_pkg::RDW_FILL & b_msk))
        else $error("collision read did not return fill");
    AST_FLOW: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (b_flow && B_CE_I && B_EN_I && !B_WE_I && !cfg_err && !OUTCLR_I)
        |=> B_Q_O == $past(f_rd))
        else $error("flow-through read late or wrong");
    AST_NO_TDP_SMALL: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (VARIANT == cerb_pkg::VAR_SMALL && MODE_I == cerb_pkg::MODE_TDP) |-> CFG_ERR_O)
        else $error("true dual-port accepted on small block");
    AST_SPLIT: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (MODE_I == cerb_pkg::MODE_SP2 && (a_wr || b_wr)) |-> (!a_row[RL-1] && b_row[RL-1]))
        else $error("split memory crossed its half");
    AST_FIFO_FULL: assert property (
        @(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (fifo && FIFO_FULL_O && !b_rd) |-> (!a_wr ##1 FIFO_FULL_O))
        else $error("full fifo accepted a push");

endmodule

// file: verif/cerb_user_model.sv
// ----------------------------------------------------------------
// fabric-side user logic driving both request ports
// ----------------------------------------------------------------
module cerb_user_model (
    input  wire logic                    clk_i,
    output logic                         a_en_o,
    output logic                         a_we_o,
    output logic [cerb_pkg::AW-1:0]      a_addr_o,
    output logic [cerb_pkg::DW-1:0]      a_data_o,
    output logic                         b_en_o,
    output logic                         b_we_o,
    output logic [cerb_pkg::AW-1:0]      b_addr_o,
    output logic [cerb_pkg::DW-1:0]      b_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle at time zero, no request pending
    initial begin
        {a_en_o, a_we_o, b_en_o, b_we_o} = 4'h0;
        {a_addr_o, a_data_o, b_addr_o, b_data_o} = '0;
    end
    // one request cycle per port; held over the taking edge only
    // write enables drop after each use, as rom emulation needs
    task automatic acc(input logic ae, input logic awe, input logic [18:0] aa,
                       input logic [143:0] ad, input logic be, input logic bwe,
                       input logic [18:0] ba, input logic [143:0] bd);
        @(posedge clk_i);
        a_en_o   <= ae;
        a_we_o   <= awe;
        a_addr_o <= aa;
        a_data_o <= ad;
        b_en_o   <= be;
        b_we_o   <= bwe;
        b_addr_o <= ba;
        b_data_o <= bd;
        @(posedge clk_i);
        {a_en_o, a_we_o, b_en_o, b_we_o} <= 4'h0;
        // released lines flip so stale values never look valid
        a_addr_o <= ~aa;
        a_data_o <= ~ad;
        b_addr_o <= ~ba;
        b_data_o <= ~bd;
    endtask
endmodule

// file: verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;      // 200 mhz system clock
    logic                 rstn = 1'b0;     // sync reset, active low
    cerb_pkg::cerb_mode_e mode = cerb_pkg::MODE_SDP;
    logic [2:0]           a_lw = 3'h3;     // width codes per port
    logic [2:0]           b_lw = 3'h3;
    logic                 a_par = 1'b0;    // parity lanes per port
    logic                 b_par = 1'b0;
    logic                 outreg = 1'b0;   // output register use
    logic                 rdw_old = 1'b1;  // collision returns old data
    logic                 inclr = 1'b0;
    logic                 outclr = 1'b0;
    logic                 a_en, a_we, b_en, b_we, empty;
    logic                 flow = 1'b0;     // flow-through on port b
    logic [18:0]          a_addr, b_addr;
    logic [143:0]         a_data, b_data, a_q, b_q, d0, d1, pat;
    int                   failures = 0;
    int                   check_count = 0;
    int                   seed = 32'h672086c9;
    always #2.5 clk = ~clk;
    cerb_ram_top #(.VARIANT(cerb_pkg::VAR_MEDIUM)) dut (
        .SYS_CLK_I(clk), .RSTN_I(rstn), .MODE_I(mode), .A_LW_I(a_lw), .A_PAR_I(a_par),
        .B_LW_I(b_lw), .B_PAR_I(b_par), .OUTREG_I(outreg), .FLOW_I(flow),
        .RDW_OLD_I(rdw_old), .INCLR_I(inclr), .OUTCLR_I(outclr), .A_CE_I(1'b1),
        .A_EN_I(a_en), .A_WE_I(a_we), .A_ADDR_I(a_addr), .A_DATA_I(a_data),
        .B_CE_I(1'b1), .B_EN_I(b_en), .B_WE_I(b_we), .B_ADDR_I(b_addr),
        .B_DATA_I(b_data), .A_Q_O(a_q), .B_Q_O(b_q), .FIFO_FULL_O(),
        .FIFO_EMPTY_O(empty), .CFG_ERR_O());
    cerb_user_model usr (.clk_i(clk), .a_en_o(a_en), .a_we_o(a_we), .a_addr_o(a_addr),
        .a_data_o(a_data), .b_en_o(b_en), .b_we_o(b_we), .b_addr_o(b_addr),
        .b_data_o(b_data));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [143:0] seen, input logic [143:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: read %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // mask of a port width; undefined reads show all ones under it
    function automatic logic [143:0] msk(input logic [2:0] lw, input logic par);
        msk = par ? ((144'h1 << (9 << (lw - 3))) - 1) : ((144'h1 << (1 << lw)) - 1);
    endfunction
    // settle: step past the edge that updates the read data
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    // watchdog: the run never hangs past this bound
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        settle();
        chk(b_q, '0);
        // random simple dual traffic, byte and parity widths
        for (int i = 0; i < 8; i++) begin
            d0 = $random(seed) & msk(3, i[0]);
            d1 = $random(seed) & 19'h1ff;
            @(posedge clk);
            a_par <= i[0];
            b_par <= i[0];
            usr.acc(1, 1, d1[18:0], d0, 0, 0, 0, 0);
            usr.acc(0, 0, 0, 0, 1, 0, d1[18:0], 0);
            settle();
            chk(b_q, d0);
        end
        $display("test sdp random done");
        // single bits written on a, sixteen read on b
        pat = $random(seed) & 144'hffff;
        @(posedge clk);
        a_lw <= 3'h0;
        b_lw <= 3'h4;
        {a_par, b_par} <= 2'b00;
        for (int i = 0; i < 16; i++) usr.acc(1, 1, i, pat >> i, 0, 0, 0, 0);
        usr.acc(0, 0, 0, 0, 1, 0, 0, 0);
        settle();
        chk(b_q, pat);
        $display("test mixed width done");
        // collision: old data or undefined ones, as configured
        a_lw <= 3'h3;
        b_lw <= 3'h3;
        usr.acc(1, 1, 19'h2a, 144'h5c, 0, 0, 0, 0);
        for (int r = 1; r >= 0; r--) begin
            rdw_old <= r[0];
            usr.acc(1, 1, 19'h2a, 144'ha0 + r, 1, 0, 19'h2a, 0);
            settle();
            chk(b_q, r ? 144'h5c : msk(3, 0));
        end
        // input clear kills the pending write
        inclr <= 1'b1;
        usr.acc(1, 1, 19'h2a, 144'h33, 0, 0, 0, 0);
        inclr <= 1'b0;
        usr.acc(0, 0, 0, 0, 1, 0, 19'h2a, 0);
        settle();
        chk(b_q, 144'ha0);
        $display("test collision and clear done");
        // single port: new data shows on a after the write
        mode <= cerb_pkg::MODE_SP;
        for (int o = 0; o < 2; o++) begin
            @(posedge clk);
            outreg <= o[0];
            d0 = $random(seed) & 144'hff;
            usr.acc(1, 1, 19'h11, d0, 0, 0, 0, 0);
            settle();
            if (o) settle();
            chk(a_q, d0);
        end
        @(posedge clk);
        outclr <= 1'b1;
        #1;
        chk(a_q, '0);
        @(posedge clk);
        outclr <= 1'b0;
        outreg <= 1'b0;
        $display("test single port done");
        // true dual: two writes, then two reads crossed over
        mode <= cerb_pkg::MODE_TDP;
        usr.acc(1, 1, 19'h40, 144'h81, 1, 1, 19'h41, 144'h7e);
        usr.acc(1, 0, 19'h41, 0, 1, 0, 19'h40, 0);
        settle();
        chk(a_q, 144'h7e);
        chk(b_q, 144'h81);
        $display("test true dual done");
        // fifo: one push, one pop, then empty again
        mode <= cerb_pkg::MODE_FIFO;
        d0 = $random(seed) & 144'hff;
        usr.acc(1, 1, 0, d0, 0, 0, 0, 0);
        usr.acc(0, 0, 0, 0, 1, 0, 0, 0);
        settle();
        chk(b_q, d0);
        chk(empty, 1);
        // flow-through: read shows right after its taking edge
        mode <= cerb_pkg::MODE_SDP;
        flow <= 1'b1;
        usr.acc(0, 0, 0, 0, 1, 0, 19'h2a, 0);
        #1;
        chk(b_q, 144'ha0);
        $display("test fifo and flow done");
        close_out();
    end
endmodule
